// >>> rtl/audio_input_ctrl_pkg.sv
/*
  Constants for the audio input gain and mute control registers.
  Assumes 7-bit register addresses and 9-bit data words, as carried by the
  codec's serial control port.
*/
package audio_input_ctrl_pkg;

  // ***********************************************************
  // Word layout
  // ***********************************************************
  localparam int ADDR_W = 7;
  localparam int DATA_W = 9;
  localparam int GAIN_W = 5;

  // ***********************************************************
  // Register addresses
  // ***********************************************************
  localparam logic [ADDR_W-1:0] LEFT_LINE_INPUT_CONTROL_ADDR = 7'h00;
  localparam logic [ADDR_W-1:0] RIGHT_LINE_INPUT_CONTROL_ADDR = 7'h01;
  localparam logic [ADDR_W-1:0] ANALOG_PATH_CONTROL_ADDR = 7'h04;

  // ***********************************************************
  // Field positions
  // ***********************************************************
  localparam int GAIN_LSB = 0;
  localparam int GAIN_MSB = 4;
  localparam int LINE_MUTE_BIT = 7;
  localparam int PAIRED_LOAD_BIT = 8;
  localparam int MIC_BOOST_BIT = 0;
  localparam int MIC_MUTE_BIT = 1;
  localparam int BYPASS_BIT = 3;
  localparam int SIDETONE_BIT = 5;

  // ***********************************************************
  // Reset values
  // ***********************************************************
  localparam logic [GAIN_W-1:0] GAIN_RESET = 5'h17;
  localparam logic LINE_MUTE_RESET = 1'b1;
  localparam logic PAIRED_LOAD_RESET = 1'b0;
  localparam logic MIC_BOOST_RESET = 1'b0;
  localparam logic MIC_MUTE_RESET = 1'b1;
  localparam logic BYPASS_RESET = 1'b1;
  localparam logic SIDETONE_RESET = 1'b0;
  localparam logic [DATA_W-1:0] READ_ZERO = 9'h000;

endpackage

// >>> rtl/line_channel_reg.sv
/*
  One line input channel: gain code and ADC mute, loaded as a pair.
  Assumes the caller has already merged direct and paired-load writes.
*/
`timescale 1ns/10ps
module line_channel_reg
  import audio_input_ctrl_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic load_i,
  input wire logic [GAIN_W-1:0] gain_i,
  input wire logic mute_i,
  output logic [GAIN_W-1:0] gain_o,
  output logic mute_o
);

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      gain_o <= GAIN_RESET;
      mute_o <= LINE_MUTE_RESET;
    end else if (load_i) begin
      gain_o <= gain_i;
      mute_o <= mute_i;
    end
  end

endmodule

// >>> rtl/audio_input_gain_mute_control.sv
/*
  Control registers for the analog input stage: line gains and mutes, paired
  loads, microphone boost and mute, and the routing enables derived from them.
  Assumes the serial control port has been decoded into single-cycle write
  strobes with address and 9-bit data, and a read address sampled each cycle.
*/
// Contract
// - Left line gain, five bits, default 10111, 1.5 dB log steps.
// - Right line gain, same mapping and default 10111.
// - Left bit 7 mutes left line into ADC; resets to 1.
// - Right bit 7 mutes right line into ADC; resets to 1.
// - Left write with bit 8 also loads right gain and mute.
// - Right write with bit 8 also loads left gain and mute.
// - Line mutes gate only ADC path; bypass still reaches line output.
// - Analog path bit 0 enables fixed 20 dB mic boost; default 0.
// - Analog path bit 1 mutes mic into ADC; sidetone path unaffected.
// - Channel written without paired bit leaves other channel unchanged.
`timescale 1ns/10ps
module audio_input_gain_mute_control
  import audio_input_ctrl_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic wr_en_i,
  input wire logic [ADDR_W-1:0] wr_addr_i,
  input wire logic [DATA_W-1:0] wr_data_i,
  input wire logic [ADDR_W-1:0] rd_addr_i,
  output logic [DATA_W-1:0] rd_data_o,
  output logic [GAIN_W-1:0] left_line_gain_o,
  output logic [GAIN_W-1:0] right_line_gain_o,
  output logic left_line_adc_mute_o,
  output logic right_line_adc_mute_o,
  output logic mic_boost_enable_o,
  output logic mic_adc_mute_o,
  output logic left_line_to_adc_o,
  output logic right_line_to_adc_o,
  output logic line_to_output_o,
  output logic mic_to_adc_o,
  output logic mic_to_output_o
);

  // ***********************************************************
  // Decode
  // ***********************************************************
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] reg_addr);
    hit = (a == reg_addr);
  endfunction

  logic wr_left;
  logic wr_right;
  logic wr_analog;
  logic paired;
  logic load_left;
  logic load_right;
  logic left_to_right_paired_load;
  logic right_to_left_paired_load;
  logic bypass_enable;
  logic sidetone_enable;

  assign wr_left = wr_en_i && hit(wr_addr_i, LEFT_LINE_INPUT_CONTROL_ADDR);
  assign wr_right = wr_en_i && hit(wr_addr_i, RIGHT_LINE_INPUT_CONTROL_ADDR);
  assign wr_analog = wr_en_i && hit(wr_addr_i, ANALOG_PATH_CONTROL_ADDR);
  assign paired = wr_data_i[PAIRED_LOAD_BIT];
  // A paired write copies the written fields into the far channel too
  assign load_left = wr_left || (wr_right && paired);
  assign load_right = wr_right || (wr_left && paired);

  // ***********************************************************
  // Channel registers
  // ***********************************************************
  line_channel_reg left_channel (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .load_i(load_left),
    .gain_i(wr_data_i[GAIN_MSB:GAIN_LSB]),
    .mute_i(wr_data_i[LINE_MUTE_BIT]),
    .gain_o(left_line_gain_o),
    .mute_o(left_line_adc_mute_o)
  );

  line_channel_reg right_channel (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .load_i(load_right),
    .gain_i(wr_data_i[GAIN_MSB:GAIN_LSB]),
    .mute_i(wr_data_i[LINE_MUTE_BIT]),
    .gain_o(right_line_gain_o),
    .mute_o(right_line_adc_mute_o)
  );

  // Paired-load bits are kept only in the register that was written
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      left_to_right_paired_load <= PAIRED_LOAD_RESET;
      right_to_left_paired_load <= PAIRED_LOAD_RESET;
    end else begin
      if (wr_left) begin
        left_to_right_paired_load <= paired;
      end
      if (wr_right) begin
        right_to_left_paired_load <= paired;
      end
    end
  end

  // ***********************************************************
  // Analog path register
  // ***********************************************************
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      mic_boost_enable_o <= MIC_BOOST_RESET;
      mic_adc_mute_o <= MIC_MUTE_RESET;
      bypass_enable <= BYPASS_RESET;
      sidetone_enable <= SIDETONE_RESET;
    end else if (wr_analog) begin
      mic_boost_enable_o <= wr_data_i[MIC_BOOST_BIT];
      mic_adc_mute_o <= wr_data_i[MIC_MUTE_BIT];
      bypass_enable <= wr_data_i[BYPASS_BIT];
      sidetone_enable <= wr_data_i[SIDETONE_BIT];
    end
  end

  // ***********************************************************
  // Routing enables
  // ***********************************************************
  // Registered for clean outputs, so they trail the control bits by one cycle
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      left_line_to_adc_o <= 1'b0;
      right_line_to_adc_o <= 1'b0;
      line_to_output_o <= 1'b0;
      mic_to_adc_o <= 1'b0;
      mic_to_output_o <= 1'b0;
    end else begin
      left_line_to_adc_o <= !left_line_adc_mute_o;
      right_line_to_adc_o <= !right_line_adc_mute_o;
      line_to_output_o <= bypass_enable;
      mic_to_adc_o <= !mic_adc_mute_o;
      mic_to_output_o <= sidetone_enable;
    end
  end

  // ***********************************************************
  // Read back
  // ***********************************************************
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rd_data_o <= READ_ZERO;
    end else begin
      rd_data_o <= READ_ZERO;
      if (hit(rd_addr_i, LEFT_LINE_INPUT_CONTROL_ADDR)) begin
        rd_data_o[GAIN_MSB:GAIN_LSB] <= left_line_gain_o;
        rd_data_o[LINE_MUTE_BIT] <= left_line_adc_mute_o;
        rd_data_o[PAIRED_LOAD_BIT] <= left_to_right_paired_load;
      end else if (hit(rd_addr_i, RIGHT_LINE_INPUT_CONTROL_ADDR)) begin
        rd_data_o[GAIN_MSB:GAIN_LSB] <= right_line_gain_o;
        rd_data_o[LINE_MUTE_BIT] <= right_line_adc_mute_o;
        rd_data_o[PAIRED_LOAD_BIT] <= right_to_left_paired_load;
      end else if (hit(rd_addr_i, ANALOG_PATH_CONTROL_ADDR)) begin
        rd_data_o[MIC_BOOST_BIT] <= mic_boost_enable_o;
        rd_data_o[MIC_MUTE_BIT] <= mic_adc_mute_o;
        rd_data_o[BYPASS_BIT] <= bypass_enable;
        rd_data_o[SIDETONE_BIT] <= sidetone_enable;
      end
    end
  end

  // ***********************************************************
  // Assertions
  // ***********************************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  reset_defaults_a: assert property ($fell(rst_i) |-> left_line_gain_o == GAIN_RESET &&
    right_line_gain_o == GAIN_RESET && left_line_adc_mute_o && right_line_adc_mute_o && mic_adc_mute_o
    && !mic_boost_enable_o) else $error("Defaults wrong after reset");
  // A direct write lands in its own channel at the next edge
  left_load_a: assert property (wr_left |=> left_line_gain_o == $past(wr_data_i[GAIN_MSB:GAIN_LSB]) &&
    left_line_adc_mute_o == $past(wr_data_i[LINE_MUTE_BIT])) else $error("Left write not stored");
  right_load_a: assert property (wr_right |=> right_line_gain_o == $past(wr_data_i[GAIN_MSB:GAIN_LSB]) &&
    right_line_adc_mute_o == $past(wr_data_i[LINE_MUTE_BIT])) else $error("Right write not stored");
  mute_to_adc_a: assert property (wr_left ##1 1'b1 |=> left_line_to_adc_o == !$past(wr_data_i[LINE_MUTE_BIT], 2))
    else $error("Left mute did not reach ADC enable");
  right_mute_a: assert property (wr_right |=> ##1 right_line_to_adc_o == !$past(wr_data_i[LINE_MUTE_BIT], 2))
    else $error("Right mute did not reach ADC enable");
  pair_lr_a: assert property (wr_left && paired |=> right_line_gain_o == left_line_gain_o &&
    right_line_adc_mute_o == left_line_adc_mute_o) else $error("Paired load left to right failed");
  pair_rl_a: assert property (wr_right && paired |=> left_line_gain_o == $past(wr_data_i[GAIN_MSB:GAIN_LSB]) &&
    left_line_adc_mute_o == $past(wr_data_i[LINE_MUTE_BIT])) else $error("Paired load right to left failed");
  bypass_path_a: assert property (wr_analog |=> ##1 line_to_output_o == $past(wr_data_i[BYPASS_BIT], 2))
    else $error("Bypass path does not follow its bit");
  // Route enables sit behind one more register, so they are checked two edges on
  sidetone_path_a: assert property (wr_analog |=> ##1 mic_to_output_o == $past(wr_data_i[SIDETONE_BIT], 2))
    else $error("Sidetone path does not follow its bit");
  mic_boost_a: assert property (wr_analog |=> mic_boost_enable_o == $past(wr_data_i[MIC_BOOST_BIT]))
    else $error("Mic boost not stored");
  mic_mute_a: assert property (wr_analog |=> mic_adc_mute_o == $past(wr_data_i[MIC_MUTE_BIT]) ##1
    mic_to_adc_o == !$past(wr_data_i[MIC_MUTE_BIT], 2)) else $error("Mic mute path wrong");
  channel_indep_a: assert property (wr_left && !paired |=> $stable(right_line_gain_o) &&
    $stable(right_line_adc_mute_o)) else $error("Unpaired write disturbed other channel");
  right_indep_a: assert property (wr_right && !paired |=> $stable(left_line_gain_o) &&
    $stable(left_line_adc_mute_o)) else $error("Unpaired write disturbed left channel");
  // Bits 6:5 are free in both line registers; the analog register has its own
  // free bits, since its bit 5 carries the sidetone enable
  unused_zero_a: assert property (hit(rd_addr_i, LEFT_LINE_INPUT_CONTROL_ADDR) ||
    hit(rd_addr_i, RIGHT_LINE_INPUT_CONTROL_ADDR) |=> rd_data_o[LINE_MUTE_BIT-1:GAIN_MSB+1] == 2'h0)
    else $error("Unassigned line bits not zero");
  analog_free_a: assert property (hit(rd_addr_i, ANALOG_PATH_CONTROL_ADDR) |=> !rd_data_o[MIC_MUTE_BIT+1] &&
    !rd_data_o[BYPASS_BIT+1] && rd_data_o[PAIRED_LOAD_BIT:SIDETONE_BIT+1] == 3'h0)
    else $error("Unassigned analog bits not zero");
  unmapped_read_a: assert property (!hit(rd_addr_i, LEFT_LINE_INPUT_CONTROL_ADDR) &&
    !hit(rd_addr_i, RIGHT_LINE_INPUT_CONTROL_ADDR) &&
    !hit(rd_addr_i, ANALOG_PATH_CONTROL_ADDR) |=> rd_data_o == READ_ZERO)
    else $error("Unmapped address did not read zero");

  // Main scenarios that a run should reach
  paired_left_c: cover property (wr_left && paired);
  paired_right_c: cover property (wr_right && paired);
  unmute_line_c: cover property (wr_left && !wr_data_i[LINE_MUTE_BIT] ##2 left_line_to_adc_o);
  mic_boost_c: cover property (wr_analog && wr_data_i[MIC_BOOST_BIT]);
  sidetone_route_c: cover property (wr_analog && wr_data_i[SIDETONE_BIT] ##2 mic_to_output_o);

endmodule

// >>> tb/tb_top.sv
/*
  Self-checking bench for the audio input gain and mute control registers.
  Assumes the serial control port is already decoded into a write strobe
  and a read address, driven here directly.
*/
`timescale 1ns/10ps
module tb_top;
  import audio_input_ctrl_pkg::*;
  // ***********************************************************
  // Stimulus and observed signals
  // ***********************************************************
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic wr_en_i = 1'b0;
  logic [ADDR_W-1:0] wr_addr_i = 7'h00;
  logic [DATA_W-1:0] wr_data_i = 9'h000;
  logic [ADDR_W-1:0] rd_addr_i = 7'h00;
  logic [DATA_W-1:0] rd_data_o;
  logic [GAIN_W-1:0] left_line_gain_o, right_line_gain_o;
  logic left_line_adc_mute_o, right_line_adc_mute_o, mic_boost_enable_o, mic_adc_mute_o;
  logic left_line_to_adc_o, right_line_to_adc_o, line_to_output_o, mic_to_adc_o, mic_to_output_o;
  int fail_count = 0;
  int cmp_count = 0;
  int cycles = 0;
  // Field outputs packed in register layout so they compare against written words; routes packed one bit each
  wire logic [8:0] left_state = {1'b0, left_line_adc_mute_o, 2'h0, left_line_gain_o};
  wire logic [8:0] right_state = {1'b0, right_line_adc_mute_o, 2'h0, right_line_gain_o};
  wire logic [8:0] mic_state = {7'h00, mic_adc_mute_o, mic_boost_enable_o};
  wire logic [8:0] routes = {4'h0, left_line_to_adc_o, right_line_to_adc_o, line_to_output_o,
    mic_to_adc_o, mic_to_output_o};

  always #5 clk_sys_i = ~clk_sys_i;

  audio_input_gain_mute_control dut_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .wr_en_i(wr_en_i),
    .wr_addr_i(wr_addr_i), .wr_data_i(wr_data_i), .rd_addr_i(rd_addr_i), .rd_data_o(rd_data_o),
    .left_line_gain_o(left_line_gain_o), .right_line_gain_o(right_line_gain_o),
    .left_line_adc_mute_o(left_line_adc_mute_o), .right_line_adc_mute_o(right_line_adc_mute_o),
    .mic_boost_enable_o(mic_boost_enable_o), .mic_adc_mute_o(mic_adc_mute_o),
    .left_line_to_adc_o(left_line_to_adc_o), .right_line_to_adc_o(right_line_to_adc_o),
    .line_to_output_o(line_to_output_o), .mic_to_adc_o(mic_to_adc_o), .mic_to_output_o(mic_to_output_o));

  // ***********************************************************
  // Shared tasks
  // ***********************************************************
  task automatic report_and_stop();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Waits one extra edge so the route enables have caught up too
  task automatic wr(input logic [6:0] a, input logic [8:0] d);
    @(posedge clk_sys_i);
    wr_en_i <= 1'b1;
    wr_addr_i <= a;
    wr_data_i <= d;
    @(posedge clk_sys_i);
    wr_en_i <= 1'b0;
    @(posedge clk_sys_i);
    #1;
  endtask

  task automatic rd(input logic [6:0] a, output logic [8:0] d);
    @(posedge clk_sys_i);
    rd_addr_i <= a;
    @(posedge clk_sys_i);
    #1;
    d = rd_data_o;
  endtask

  // Reads all three registers and compares them and the packed outputs
  task automatic expect_all(input logic [8:0] l, r, an, ls, rs, ms, rt);
    logic [8:0] d;
    rd(LEFT_LINE_INPUT_CONTROL_ADDR, d);
    check("left reg", d, l);
    rd(RIGHT_LINE_INPUT_CONTROL_ADDR, d);
    check("right reg", d, r);
    rd(ANALOG_PATH_CONTROL_ADDR, d);
    check("analog reg", d, an);
    check("left fields", left_state, ls);
    check("right fields", right_state, rs);
    check("mic fields", mic_state, ms);
    check("routes", routes, rt);
  endtask

  // ***********************************************************
  // Scenarios
  // ***********************************************************
  task automatic test_reset();
    expect_all(9'h097, 9'h097, 9'h00A, 9'h097, 9'h097, 9'h002, 9'h004);
  endtask

  task automatic test_single_writes();
    // Unassigned bits written high must not stick
    wr(LEFT_LINE_INPUT_CONTROL_ADDR, 9'h07F);
    expect_all(9'h01F, 9'h097, 9'h00A, 9'h01F, 9'h097, 9'h002, 9'h014);
  endtask

  task automatic test_paired_loads();
    wr(LEFT_LINE_INPUT_CONTROL_ADDR, 9'h105);
    expect_all(9'h105, 9'h005, 9'h00A, 9'h005, 9'h005, 9'h002, 9'h01C);
    wr(RIGHT_LINE_INPUT_CONTROL_ADDR, 9'h180);
    expect_all(9'h180, 9'h180, 9'h00A, 9'h080, 9'h080, 9'h002, 9'h004);
    wr(RIGHT_LINE_INPUT_CONTROL_ADDR, 9'h01E);
    expect_all(9'h180, 9'h01E, 9'h00A, 9'h080, 9'h01E, 9'h002, 9'h00C);
  endtask

  task automatic test_analog_path();
    wr(ANALOG_PATH_CONTROL_ADDR, 9'h1FF);
    expect_all(9'h180, 9'h01E, 9'h02B, 9'h080, 9'h01E, 9'h003, 9'h00D);
    wr(ANALOG_PATH_CONTROL_ADDR, 9'h000);
    expect_all(9'h180, 9'h01E, 9'h000, 9'h080, 9'h01E, 9'h000, 9'h00A);
  endtask

  task automatic test_unmapped();
    logic [8:0] d;
    wr(7'h02, 9'h1FF);
    wr(7'h7F, 9'h1FF);
    rd(7'h02, d);
    check("unmapped read", d, 9'h000);
    expect_all(9'h180, 9'h01E, 9'h000, 9'h080, 9'h01E, 9'h000, 9'h00A);
  endtask

  // ***********************************************************
  // Main sequence and hang guard
  // ***********************************************************
  // About 90 cycles are needed; the ceiling leaves a wide margin
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      report_and_stop();
    end
  end

  initial begin
    repeat (12) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    test_reset();
    test_single_writes();
    test_paired_loads();
    test_analog_path();
    test_unmapped();
    report_and_stop();
  end
endmodule
